/* File: common/pec_consts.svh */
// constants for the preset event counter bank
// Behaviour
// - count input off-to-on adds exactly one; steady input never counts
// - status bit on when current value is at or above preset
// - counting continues past preset up to ceiling 9999
// - at ceiling further edges leave the value unchanged until reset
// - ordinary counter reset input on forces value 0 and status off
// - value of counter n readable at data word n plus 1000
// - preset is a constant 0-9999 or a data word, supplied by program
// - counters selected by octal number, 0-77 smallest up to 0-377 largest
// - status bit reachable by number and as a bit of packed status words
// - stage counter has no reset input; cleared only by reset instruction
// - stage counter status stays on until reset instruction clears it
// - stage counter value and status reached by number, data word and packed status word alike
`ifndef PEC_CONSTS_SVH
`define PEC_CONSTS_SVH
`define PEC_NUM_CNT      256
`define PEC_NUM_W        8
`define PEC_VALUE_BASE   16'h03e8
`define PEC_BCD_MAX      16'h9999
`define PEC_BCD_ZERO     16'h0000
`define PEC_STATUS_WORDS 16
`define PEC_SEL_WORD_W   4
`endif

/* File: common/pec_pkg.sv */
// types shared by the preset event counter bank
package pec_pkg;
	typedef enum logic [1:0]
	{
		PEC_OP_NONE  = 2'b00,
		PEC_OP_EVAL  = 2'b01,
		PEC_OP_RESET = 2'b11
	} pec_op_e;

	typedef struct packed
	{
		pec_op_e     op;
		logic [7:0]  num;
		logic        stage;
		logic        count_in;
		logic        reset_in;
		logic [15:0] preset;
	} pec_req_s;

	typedef struct packed
	{
		logic [15:0] value;
		logic        status;
	} pec_cnt_s;
endpackage

/* File: tb/pec_chk.sv */
// port assertions for the counter bank
`timescale 1ns/10ps
module pec_chk
(
	input wire logic              core_clk_i,
	input wire logic              rst_b_i,
	input wire pec_pkg::pec_req_s req_i,
	input wire logic              done_o,
	input wire logic              status_o,
	input wire logic [15:0]       value_o,
	input wire logic [15:0]       rd_word_addr_i,
	input wire logic [15:0]       rd_word_o,
	input wire logic              rd_word_hit_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	// number of the op whose result stands on value_o
	logic [7:0] last_num;
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			last_num <= 8'h00;
		else if (req_i.op != pec_pkg::PEC_OP_NONE)
			last_num <= req_i.num;
	end
	// ----
	// checks
	// ----
	a_done_taken: assert property (req_i.op != 2'h0 |=> done_o)
		else $error("no done");
	a_idle_quiet: assert property (req_i.op == 2'h0 |=> !done_o)
		else $error("stray done");
	a_reset_in: assert property (req_i == {2'h1, req_i[26:0]}
		&& !req_i.stage && req_i.reset_in |=> value_o == 16'h0000 && !status_o)
		else $error("reset input");
	a_reset_op: assert property (req_i.op == 2'h3
		|=> value_o == 16'h0000 && !status_o)
		else $error("reset op");
	a_zero_pre: assert property (req_i.op == 2'h1
		&& req_i.preset == 16'h0000 && !req_i.reset_in |=> status_o)
		else $error("status");
	a_value_cap: assert property (done_o && value_o == 16'h9999
		&& req_i.op == pec_pkg::PEC_OP_EVAL && req_i.num == last_num
		&& !(req_i.reset_in && !req_i.stage) |=> value_o == 16'h9999)
		else $error("left cap");
	a_out_hold: assert property (!done_o |-> $stable(value_o))
		else $error("value moved");
	a_word_miss: assert property (rd_word_addr_i < 16'h03e8
		|=> !rd_word_hit_o && rd_word_o == 16'h0000)
		else $error("word hit");
	c_full: cover property (done_o && value_o == 16'h9999);
	c_hit: cover property (rd_word_hit_o);
	c_clr: cover property (req_i.op == 2'h3);
endmodule // pec_chk
bind pec_counter_bank pec_chk pec_chk_inst (.core_clk_i(core_clk_i),
	.rst_b_i(rst_b_i), .req_i(req_i), .done_o(done_o), .status_o(status_o),
	.value_o(value_o), .rd_word_addr_i(rd_word_addr_i),
	.rd_word_o(rd_word_o), .rd_word_hit_o(rd_word_hit_o));

/* File: tb/testbench.sv */
// self-checking bench for the counter bank
`timescale 1ns/10ps
`define CHK(a,b) begin samples_checked++; if ((a)!==(b)) begin errors++; \
	$display("[ERR] %0t %h %h", $time, a, b); end end
module testbench;
	logic              clk = 0;
	logic              rst_b = 0;
	pec_pkg::pec_req_s req;
	logic [7:0]        rd_num;
	logic [15:0]       rd_addr, val, rd_word, rd_val, sw;
	logic [3:0]        rd_sel;
	logic              done, st, rd_st, hit;
	int                errors = 0, samples_checked = 0, cyc = 0;
	pec_counter_bank pec_counter_bank_inst (.core_clk_i(clk), .rst_b_i(rst_b),
		.req_i(req), .rd_num_i(rd_num), .rd_word_addr_i(rd_addr),
		.rd_status_sel_i(rd_sel), .done_o(done), .status_o(st), .value_o(val),
		.rd_status_o(rd_st), .rd_value_o(rd_val), .rd_word_o(rd_word),
		.rd_word_hit_o(hit), .rd_status_word_o(sw));
	initial forever #25 clk = ~clk;
	// ----
	// tasks
	// ----
	task summarize;
		$display("errors %0d checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// one scan per call; op stays up so back-to-back scans never toggle it
	task go(logic x, logic [7:0] n, logic s, c, r, logic [15:0] p);
		req = {x ? pec_pkg::PEC_OP_RESET : pec_pkg::PEC_OP_EVAL, n, s, c, r, p};
		@(posedge clk);
		#1;
		`CHK(done, 1'b1)
	endtask
	task chk(logic [15:0] v, logic s);
		`CHK(val, v)
		`CHK(st, s)
	endtask
	task rd(logic [7:0] n, logic [15:0] a);
		req.op = pec_pkg::PEC_OP_NONE;
		rd_num = n;
		rd_addr = a;
		rd_sel = n[7:4];
		@(posedge clk);
		#1;
		`CHK(done, 1'b0)
	endtask
	task t_count;
		go(0, 8'h02, 0, 1, 0, 16'h0003);
		chk(16'h0001, 0);
		go(0, 8'h02, 0, 1, 0, 16'h0003);
		chk(16'h0001, 0);
		repeat (2)
		begin
			go(0, 8'h02, 0, 0, 0, 16'h0003);
			go(0, 8'h02, 0, 1, 0, 16'h0003);
		end
		chk(16'h0003, 1);
		rd(8'h02, 16'h03ea);
		`CHK({rd_word, hit}, {16'h0003, 1'b1})
		`CHK({rd_st, rd_val, sw[2]}, {1'b1, 16'h0003, 1'b1})
		go(0, 8'h02, 0, 1, 1, 16'h0003);
		chk(16'h0000, 0);
		go(0, 8'h02, 0, 0, 0, 16'h0000);
		chk(16'h0000, 1);
	endtask
	task t_stage;
		repeat (2)
		begin
			go(0, 8'h07, 1, 0, 0, 16'h0002);
			go(0, 8'h07, 1, 1, 0, 16'h0002);
		end
		go(0, 8'h07, 1, 0, 1, 16'h0002);
		chk(16'h0002, 1);
		go(0, 8'h07, 1, 0, 0, 16'h0009);
		chk(16'h0002, 1);
		rd(8'h07, 16'h03ef);
		`CHK({rd_st, rd_word}, {1'b1, 16'h0002})
		go(1, 8'h07, 1, 0, 0, 16'h0000);
		chk(16'h0000, 0);
	endtask
	task t_sat;
		repeat (10000)
		begin
			go(0, 8'hff, 0, 0, 0, 16'h9999);
			go(0, 8'hff, 0, 1, 0, 16'h9999);
		end
		chk(16'h9999, 1);
		rd(8'hff, 16'h04e7);
		`CHK({rd_word, sw[15]}, {16'h9999, 1'b1})
		`CHK(hit, 1'b1)
		rd(8'h00, 16'h04e8);
		`CHK({hit, rd_word}, {1'b0, 16'h0000})
	endtask
	// ceiling well above the ~20k cycles of the saturation run
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			errors++;
			summarize;
		end
	end
	initial
	begin
		req = '0;
		rd_num = '0;
		rd_addr = '0;
		rd_sel = '0;
		repeat (3) @(posedge clk);
		#1;
		rst_b = 1;
		t_count;
		t_stage;
		t_sat;
		summarize;
	end
endmodule // testbench

/* File: verilog/pec_bcd_cmp.sv */
// bcd greater-or-equal compare
`timescale 1ns/10ps
module pec_bcd_cmp
(
	input  wire logic [15:0] value_i,
	input  wire logic [15:0] preset_i,
	output logic             ge_o
);
	// packed bcd orders like binary, so a plain compare suffices
	always_comb
	begin
		ge_o = (value_i >= preset_i);
	end
endmodule // pec_bcd_cmp

/* File: verilog/pec_bcd_inc.sv */
// saturating four-digit bcd incrementer
`timescale 1ns/10ps
`include "pec_consts.svh"
module pec_bcd_inc
(
	input  wire logic [15:0] value_i,
	output logic      [15:0] value_o
);
	function automatic logic [15:0] bcd_inc(input logic [15:0] v);
		logic [15:0] r;
		logic        carry;
		r = v;
		carry = 1'b1;
		for (int d = 0; d < 4; d++)
		begin
			if (carry)
			begin
				if (r[d*4 +: 4] == 4'h9)
					r[d*4 +: 4] = 4'h0;
				else
				begin
					r[d*4 +: 4] = r[d*4 +: 4] + 4'h1;
					carry = 1'b0;
				end
			end
		end
		return r;
	endfunction

	always_comb
	begin
		if (value_i == `PEC_BCD_MAX)
			value_o = value_i;
		else
			value_o = bcd_inc(value_i);
	end
endmodule // pec_bcd_inc

/* File: verilog/pec_counter_bank.sv */
// bank of preset up counters and stage event counters
`timescale 1ns/10ps
`include "pec_consts.svh"
module pec_counter_bank
#(
	parameter int NUM_CNT = `PEC_NUM_CNT
)
(
	input  wire logic             core_clk_i,
	input  wire logic             rst_b_i,
	input  wire pec_pkg::pec_req_s req_i,
	input  wire logic [7:0]       rd_num_i,
	input  wire logic [15:0]      rd_word_addr_i,
	input  wire logic [3:0]       rd_status_sel_i,
	output logic                  done_o,
	output logic                  status_o,
	output logic [15:0]           value_o,
	output logic                  rd_status_o,
	output logic [15:0]           rd_value_o,
	output logic [15:0]           rd_word_o,
	output logic                  rd_word_hit_o,
	output logic [15:0]           rd_status_word_o
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [NUM_CNT-1:0][15:0] value;
		logic [NUM_CNT-1:0]       status;
		logic [NUM_CNT-1:0]       prev_in;
		logic                     done;
		logic                     out_status;
		logic [15:0]              out_value;
		logic                     rd_status;
		logic [15:0]              rd_value;
		logic [15:0]              rd_word;
		logic                     rd_hit;
		logic [15:0]              rd_sword;
	} pec_state_s;

	pec_state_s  cur;
	pec_state_s  next_cur;
	logic [15:0] sel_value;
	logic [15:0] inc_value;
	logic        ge_now;
	logic        ge_inc;
	logic [15:0] word_off;

	// ----------------------------------------------------------------
	// arithmetic
	// ----------------------------------------------------------------
	assign sel_value = cur.value[req_i.num];

	pec_bcd_inc u_inc
	(
		.value_i (sel_value),
		.value_o (inc_value)
	);

	pec_bcd_cmp u_cmp_now
	(
		.value_i  (sel_value),
		.preset_i (req_i.preset),
		.ge_o     (ge_now)
	);

	pec_bcd_cmp u_cmp_inc
	(
		.value_i  (inc_value),
		.preset_i (req_i.preset),
		.ge_o     (ge_inc)
	);

	assign word_off = rd_word_addr_i - `PEC_VALUE_BASE;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_cur = cur;
		next_cur.done = 1'b0;
		unique case (req_i.op)
			pec_pkg::PEC_OP_EVAL:
			begin
				next_cur.done = 1'b1;
				next_cur.prev_in[req_i.num] = req_i.count_in;
				if (!req_i.stage && req_i.reset_in)
				begin
					next_cur.value[req_i.num] = `PEC_BCD_ZERO;
					next_cur.status[req_i.num] = 1'b0;
				end
				else if (req_i.count_in && !cur.prev_in[req_i.num])
				begin
					next_cur.value[req_i.num] = inc_value;
					// stage counters latch on; reset instruction only
					if (req_i.stage)
						next_cur.status[req_i.num] =
							cur.status[req_i.num] | ge_inc;
					else
						next_cur.status[req_i.num] = ge_inc;
				end
				else if (req_i.stage)
					next_cur.status[req_i.num] =
						cur.status[req_i.num] | ge_now;
				else
					next_cur.status[req_i.num] = ge_now;
				next_cur.out_status = next_cur.status[req_i.num];
				next_cur.out_value = next_cur.value[req_i.num];
			end
			pec_pkg::PEC_OP_RESET:
			begin
				next_cur.done = 1'b1;
				next_cur.value[req_i.num] = `PEC_BCD_ZERO;
				next_cur.status[req_i.num] = 1'b0;
				next_cur.out_status = 1'b0;
				next_cur.out_value = `PEC_BCD_ZERO;
			end
			default:
			begin
				next_cur.done = 1'b0;
			end
		endcase
		// read side: by number, by data word, by packed status word
		next_cur.rd_status = cur.status[rd_num_i];
		next_cur.rd_value = cur.value[rd_num_i];
		next_cur.rd_hit = (rd_word_addr_i >= `PEC_VALUE_BASE) &&
			(word_off < 16'(NUM_CNT));
		next_cur.rd_word = next_cur.rd_hit ?
			cur.value[word_off[7:0]] : `PEC_BCD_ZERO;
		next_cur.rd_sword = '0;
		for (int b = 0; b < 16; b++)
		begin
			if ({rd_status_sel_i, 4'(b)} < NUM_CNT)
				next_cur.rd_sword[b] =
					cur.status[{rd_status_sel_i, 4'(b)}];
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign done_o           = cur.done;
	assign status_o         = cur.out_status;
	assign value_o          = cur.out_value;
	assign rd_status_o      = cur.rd_status;
	assign rd_value_o       = cur.rd_value;
	assign rd_word_o        = cur.rd_word;
	assign rd_word_hit_o    = cur.rd_hit;
	assign rd_status_word_o = cur.rd_sword;
endmodule // pec_counter_bank
